//--- hps_host_model.sv
// host processor model driving the parallel port pins
`timescale 1ns/10ps
`default_nettype none
module hps_host_model (
  input wire logic clk_sys,
  input wire logic [hps_pkg::DATA_W-1:0] dout,
  input wire logic oe,
  output logic mode,
  output logic cs_n,
  output logic pclk,
  output logic stb_n,
  output logic wnr,
  output logic [hps_pkg::ADDR_W-1:0] addr,
  output logic [hps_pkg::DATA_W-1:0] data
);
  logic [2:0] div_q = 3'h0;
  initial
  begin
    {mode, cs_n, pclk, stb_n, wnr} = 5'h0F;
    addr = 11'h000;
    data = 8'h00;
  end
  always @(negedge clk_sys)
  begin
    div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
    if (div_q == 3'h4)
      pclk <= ~pclk;
  end
  task automatic acc(input logic m, input logic w, input logic r, input logic sel, input logic stb,
    input logic [hps_pkg::ADDR_W-1:0] a, input logic [hps_pkg::DATA_W-1:0] d,
    output logic [hps_pkg::DATA_W-1:0] q, output logic seen);
    @(negedge pclk);
    mode = m;
    cs_n = ~sel;
    addr = a;
    data = d;
    stb_n = m ? ~stb : 1'b1;
    wnr = m ? w : 1'b1;
    repeat (3) @(negedge clk_sys);
    if (!m)
      stb_n = ~w;
    if (!m)
      wnr = ~r;
    repeat (8) @(negedge clk_sys);
    q = dout;
    seen = oe;
    stb_n = 1'b1;
    wnr = 1'b1;
    repeat (3) @(negedge clk_sys);
    cs_n = 1'b1;
  endtask : acc
endmodule : hps_host_model
`default_nettype wire

//--- hps_host_port.sv
// parallel host port: dual-role strobe and 11-bit register address decode
// Function
// - mode high: shared pin is address strobe
// - sync address valid only while strobe low
// - sync accesses need asserted address strobe
// - mode low: shared pin is write strobe
// - async write strobe low stores data bus
// - async write needs select, read high, reset
// - 11-bit address selects target register
// - sync control high writes, low reads
// - async read strobe low drives data
// - chip select high: ignore pins, bus released
`timescale 1ns/10ps
`default_nettype none
module hps_host_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bus_timing_select,
  input wire logic host_chip_select_n,
  input wire logic host_port_clk,
  input wire logic addr_strobe_n,
  input wire logic sync_write_not_read,
  input wire logic [hps_pkg::ADDR_W-1:0] host_reg_addr,
  input wire logic [hps_pkg::DATA_W-1:0] host_data_bus_in,
  output logic [hps_pkg::DATA_W-1:0] host_data_bus_out,
  output logic host_data_bus_oe
);
  logic [hps_pkg::SYNC_W-1:0] pin_s1_q;
  logic [hps_pkg::SYNC_W-1:0] pin_s2_q;
  logic port_clk_prev_q;
  logic sync_rd_sel_q;
  logic [hps_pkg::DATA_W-1:0] data_out_q;
  logic data_oe_q;
  logic port_clk_rise;
  logic mode_sync;
  logic cs_n;
  logic addr_strobe_s;
  logic async_write_strobe_n;
  logic async_read_strobe_n;
  logic write_not_read;
  logic [hps_pkg::ADDR_W-1:0] addr_s;
  logic [hps_pkg::DATA_W-1:0] data_s;
  logic sync_access;
  logic wr_en_d;

  hps_mem_if m_if ();

  hps_reg_mem u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port(m_if.mem)
  );

  // two-stage synchroniser for every pin
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= hps_pkg::SYNC_RST;
      pin_s2_q <= hps_pkg::SYNC_RST;
    end
    else
    begin
      pin_s1_q <= {host_data_bus_in, host_reg_addr, bus_timing_select, host_chip_select_n,
                   sync_write_not_read, addr_strobe_n, host_port_clk};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign mode_sync = pin_s2_q[hps_pkg::POS_MODE];
  assign cs_n = pin_s2_q[hps_pkg::POS_CS];
  assign addr_strobe_s = mode_sync ? pin_s2_q[hps_pkg::POS_STROBE] : 1'b1;
  assign async_write_strobe_n = mode_sync ? 1'b1 : pin_s2_q[hps_pkg::POS_STROBE];
  assign write_not_read = pin_s2_q[hps_pkg::POS_WNR];
  assign async_read_strobe_n = mode_sync ? 1'b1 : pin_s2_q[hps_pkg::POS_WNR];
  assign addr_s = pin_s2_q[hps_pkg::POS_DATA-1:hps_pkg::POS_ADDR];
  assign data_s = pin_s2_q[hps_pkg::SYNC_W-1:hps_pkg::POS_DATA];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_clk_prev_q <= 1'b0;
    end
    else
    begin
      port_clk_prev_q <= pin_s2_q[hps_pkg::POS_CLK];
    end
  end

  assign port_clk_rise = pin_s2_q[hps_pkg::POS_CLK] && !port_clk_prev_q;

  assign sync_access = mode_sync && port_clk_rise && !cs_n && !addr_strobe_s;

  always_comb
  begin
    wr_en_d = 1'b0;
    if (sync_access && write_not_read)
    begin
      wr_en_d = 1'b1;
    end
    else if (!mode_sync && !cs_n && !async_write_strobe_n && async_read_strobe_n)
    begin
      wr_en_d = 1'b1;
    end
  end

  assign m_if.wr_en = wr_en_d;
  assign m_if.wr_addr = addr_s;
  assign m_if.wr_data = data_s;
  assign m_if.rd_addr = addr_s;

  // sync read selection held between port clock edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_rd_sel_q <= 1'b0;
    end
    else if (cs_n || !mode_sync)
    begin
      sync_rd_sel_q <= 1'b0;
    end
    else if (port_clk_rise)
    begin
      sync_rd_sel_q <= !addr_strobe_s && !write_not_read;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_oe_q <= 1'b0;
    end
    else
    begin
      data_oe_q <= !cs_n && (mode_sync ? sync_rd_sel_q : !async_read_strobe_n);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_out_q <= hps_pkg::DATA_RST;
    end
    else
    begin
      data_out_q <= m_if.rd_data;
    end
  end

  assign host_data_bus_out = data_out_q;
  assign host_data_bus_oe = data_oe_q;

  chk_sync_strobe_role: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (mode_sync && port_clk_rise && !cs_n && !pin_s2_q[hps_pkg::POS_STROBE] && write_not_read) |-> m_if.wr_en)
    else $error("sync write with strobe low not performed");

  chk_sync_strobe_qual: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (m_if.wr_en && mode_sync) |-> (!pin_s2_q[hps_pkg::POS_STROBE] && port_clk_rise && !cs_n))
    else $error("sync write without strobe or clock edge");

  chk_async_write_role: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!mode_sync && !cs_n && !pin_s2_q[hps_pkg::POS_STROBE] && write_not_read) |-> m_if.wr_en)
    else $error("async write strobe low but no write");

  chk_async_write_cond: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (m_if.wr_en && !mode_sync) |-> (!cs_n && write_not_read && !pin_s2_q[hps_pkg::POS_STROBE]))
    else $error("async write without select or with read low");

  chk_write_target: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    m_if.wr_en |-> (m_if.wr_addr == pin_s2_q[hps_pkg::POS_DATA-1:hps_pkg::POS_ADDR]
                    && m_if.wr_data == pin_s2_q[hps_pkg::SYNC_W-1:hps_pkg::POS_DATA]))
    else $error("write address or data not from the pins");

  chk_sync_read_drive: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (sync_access && !write_not_read) ##1 (!cs_n && mode_sync) |=> host_data_bus_oe)
    else $error("sync read did not drive the bus");

  chk_async_read_drive: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!mode_sync && !cs_n && !write_not_read) |=> host_data_bus_oe)
    else $error("async read strobe low but bus not driven");

  chk_deselect_release: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cs_n |=> (!host_data_bus_oe && !$past(m_if.wr_en)))
    else $error("bus driven or write done while deselected");

  chk_read_data_path: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (host_data_bus_oe && $stable(m_if.rd_addr)) ##1 $stable(m_if.rd_addr) ##1 !m_if.wr_en
      |-> host_data_bus_out == $past(m_if.rd_data))
    else $error("bus data not from addressed register");
endmodule : hps_host_port
`default_nettype wire

//--- hps_mem_if.sv
// internal write and read port between decode logic and register store
`timescale 1ns/10ps
`default_nettype none
interface hps_mem_if;
  logic wr_en;
  logic [hps_pkg::ADDR_W-1:0] wr_addr;
  logic [hps_pkg::DATA_W-1:0] wr_data;
  logic [hps_pkg::ADDR_W-1:0] rd_addr;
  logic [hps_pkg::DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : hps_mem_if
`default_nettype wire

//--- hps_pkg.sv
// constants shared by the host port strobe and address decode block
package hps_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 2048;
  localparam int SYNC_W = 5 + ADDR_W + DATA_W;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [SYNC_W-1:0] SYNC_RST = 24'h00_001E;
  // positions inside the synchronised pin vector
  localparam int POS_CLK = 0;
  localparam int POS_STROBE = 1;
  localparam int POS_WNR = 2;
  localparam int POS_CS = 3;
  localparam int POS_MODE = 4;
  localparam int POS_ADDR = 5;
  localparam int POS_DATA = 5 + ADDR_W;
endpackage : hps_pkg

//--- hps_reg_mem.sv
// register store with registered read data
`timescale 1ns/10ps
`default_nettype none
module hps_reg_mem (
  input wire logic clk_sys,
  input wire logic rst_n,
  hps_mem_if.mem port
);
  logic [hps_pkg::DATA_W-1:0] store [hps_pkg::MEM_DEPTH];
  logic [hps_pkg::DATA_W-1:0] rd_data_q;

  always_ff @(posedge clk_sys)
  begin
    if (port.wr_en)
    begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= hps_pkg::DATA_RST;
    end
    else
    begin
      rd_data_q <= store[port.rd_addr];
    end
  end

  assign port.rd_data = rd_data_q;
endmodule : hps_reg_mem
`default_nettype wire

//--- tb.sv
// self-checking bench for the host port block
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct packed {logic m; logic w; logic [hps_pkg::ADDR_W-1:0] a; logic [hps_pkg::DATA_W-1:0] d;} hps_row_s;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic mode, cs_n, pclk, stb_n, wnr, oe, seen;
  logic [hps_pkg::ADDR_W-1:0] addr;
  logic [hps_pkg::DATA_W-1:0] hdata, dout, q;
  int fails = 0;
  int cmp_count = 0;
  hps_row_s rows [8] = '{'{1'b1, 1'b1, 11'h000, 8'hA5}, '{1'b1, 1'b0, 11'h000, 8'hA5},
    '{1'b1, 1'b1, 11'h7FF, 8'h3C}, '{1'b0, 1'b0, 11'h7FF, 8'h3C}, '{1'b0, 1'b1, 11'h400, 8'h5A},
    '{1'b1, 1'b0, 11'h400, 8'h5A}, '{1'b0, 1'b1, 11'h001, 8'hFF}, '{1'b0, 1'b0, 11'h001, 8'hFF}};
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  hps_host_port u_hps_host_port (.clk_sys(clk_sys), .rst_n(rst_n), .bus_timing_select(mode),
    .host_chip_select_n(cs_n), .host_port_clk(pclk), .addr_strobe_n(stb_n), .sync_write_not_read(wnr),
    .host_reg_addr(addr), .host_data_bus_in(oe ? dout : hdata), .host_data_bus_out(dout), .host_data_bus_oe(oe));
  hps_host_model u_hps_host_model (.clk_sys(clk_sys), .dout(dout), .oe(oe), .mode(mode), .cs_n(cs_n),
    .pclk(pclk), .stb_n(stb_n), .wnr(wnr), .addr(addr), .data(hdata));
  task automatic chk(input logic [hps_pkg::DATA_W-1:0] got, input logic [hps_pkg::DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic go(input logic m, input logic w, input logic r, input logic sel, input logic stb,
    input logic [hps_pkg::ADDR_W-1:0] a, input logic [hps_pkg::DATA_W-1:0] d,
    input logic [hps_pkg::DATA_W-1:0] e, input logic eoe);
    u_hps_host_model.acc(m, w, r, sel, stb, a, d, q, seen);
    chk({7'h00, seen}, {7'h00, eoe}); // drive state
    if (eoe)
      chk(q, e); // read data
  endtask : go
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    test_done();
  end
  initial
  begin
    repeat (5) @(negedge clk_sys);
    chk({7'h00, oe}, 8'h00); // quiet in reset
    chk(dout, 8'h00); // quiet in reset
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    foreach (rows[i])
      go(rows[i].m, rows[i].w, ~rows[i].w, 1'b1, 1'b1, rows[i].a, rows[i].d, rows[i].d, ~rows[i].w);
    go(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 11'h000, 8'h11, 8'h00, 1'b0); // sync unselected
    go(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 11'h400, 8'h22, 8'h00, 1'b0); // write no strobe
    go(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 11'h400, 8'h22, 8'h00, 1'b0); // read no strobe
    go(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 11'h7FF, 8'h99, 8'h3C, 1'b1); // write during read
    go(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 11'h7FF, 8'h3C, 8'h00, 1'b0); // async unselected
    go(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 11'h001, 8'h00, 8'h00, 1'b0); // async unselected
    rst_n = 1'b0;
    go(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 11'h001, 8'h00, 8'h00, 1'b0); // write in reset
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    go(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 11'h000, 8'h00, 8'hA5, 1'b1); // value kept
    go(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 11'h400, 8'h00, 8'h5A, 1'b1); // value kept
    go(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 11'h7FF, 8'h00, 8'h3C, 1'b1); // value kept
    go(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 11'h001, 8'h00, 8'hFF, 1'b1); // value kept
    test_done();
  end
endmodule : tb
`default_nettype wire
